// File: core/clock_ctrl_pkg.sv
// Constants, encodings and register map of the clock control block
package clock_ctrl_pkg;

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] ADDR_TUNING = 4'h0;
  localparam logic [3:0] ADDR_CONTROL = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;

  // ----------------------------------------
  // Tuning register fields
  // ----------------------------------------
  localparam int TUNE_SRC_BIT = 7;
  localparam int TUNE_PLL_BIT = 6;
  localparam int TRIM_W = 6;
  localparam logic [7:0] TUNING_RESET = 8'h00;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int CTRL_USE_INT_BIT = 3;
  localparam int FREQ_SEL_W = 3;
  localparam logic [3:0] CONTROL_RESET = 4'h0;
  localparam logic [2:0] FREQ_SEL_LOW = 3'h0;
  localparam logic [2:0] FREQ_SEL_FAST = 3'h7;

  // ----------------------------------------
  // Status register fields
  // ----------------------------------------
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_PLL_RUN_BIT = 1;
  localparam int STAT_READY_BIT = 2;
  localparam int STAT_SLOW_RC_BIT = 3;
  localparam int STAT_MODE_LSB = 4;

  // ----------------------------------------
  // Oscillator modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    internal_osc_mode = 3'b000,
    internal_osc_clkout_mode = 3'b001,
    internal_osc_pll_mode = 3'b010,
    internal_osc_pll_clkout_mode = 3'b011,
    high_speed_crystal_mode = 3'b100,
    high_speed_crystal_pll_mode = 3'b101,
    external_clock_mode = 3'b110,
    external_clock_pll_mode = 3'b111
  } osc_mode_type;

  // ----------------------------------------
  // Dividers
  // ----------------------------------------
  localparam int DIV_W = 9;
  localparam int DIV_COUNT = 6;
  localparam int DV_PRESCALE = 0;
  localparam int DV_POSTSCALE = 1;
  localparam int DV_LOW_FREQ = 2;
  localparam int DV_PLL_HALF = 3;
  localparam int DV_CPU = 4;
  localparam int DV_CLKOUT = 5;
  localparam logic [8:0] DIV_LOW_FREQ = 9'h100;
  localparam logic [8:0] DIV_PLL_HALF = 9'h002;
  localparam logic [8:0] DIV_CLKOUT_HALF = 9'h002;
  localparam logic [8:0] DIV_ONE = 9'h001;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int PLL_LOCK_REF_TICKS = 64;
  localparam int OSC_START_TICKS = 1024;
  localparam int CNT_W = 16;

  // PLL input prescaler: eight settings down to the 4 MHz reference
  function automatic logic [8:0] prescale_div(input logic [2:0] sel);
    logic [8:0] d;
    d = DIV_ONE;
    unique case (sel)
      3'b000: d = 9'h00c;
      3'b001: d = 9'h00a;
      3'b010: d = 9'h006;
      3'b011: d = 9'h005;
      3'b100: d = 9'h004;
      3'b101: d = 9'h003;
      3'b110: d = 9'h002;
      3'b111: d = 9'h001;
    endcase
    return d;
  endfunction

  // CPU divider: 11 none, 10 half, 01 third, 00 sixth
  function automatic logic [8:0] cpu_div(input logic [1:0] sel);
    logic [8:0] d;
    d = DIV_ONE;
    unique case (sel)
      2'b11: d = 9'h001;
      2'b10: d = 9'h002;
      2'b01: d = 9'h003;
      2'b00: d = 9'h006;
    endcase
    return d;
  endfunction

endpackage

// File: core/osc_clock_ctrl.sv
// Oscillator modes, PLL control and clock selection as tick enables
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module osc_clock_ctrl #(
  parameter int PLL_LOCK_TICKS = clock_ctrl_pkg::PLL_LOCK_REF_TICKS,
  parameter int START_TICKS = clock_ctrl_pkg::OSC_START_TICKS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Nonvolatile configuration, caught after reset
  input wire logic [2:0] osc_mode_cfg,
  input wire logic [2:0] pll_prescale_cfg,
  input wire logic [1:0] cpu_clock_divider_select,
  // Oscillator and PLL edge ticks
  input wire logic oscillator_input_pin,
  input wire logic fast_osc_tick,
  input wire logic slow_rc_tick,
  input wire logic pll_vco_tick,
  // Features that need the slow RC oscillator, and the sleep request
  input wire logic powerup_timer_en,
  input wire logic failsafe_monitor_en,
  input wire logic watchdog_en,
  input wire logic two_speed_start_en,
  input wire logic sleep_req,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Clock outputs
  output logic core_tick,
  output logic pll_ref_tick,
  output logic pll_power_en,
  output logic slow_rc_run,
  output logic signed [5:0] fast_osc_trim,
  output logic oscillator_output_pin_o,
  output logic oscillator_output_pin_oe
);

  // ----------------------------------------
  // Configuration capture
  // ----------------------------------------
  logic cfg_valid_q;
  clock_ctrl_pkg::osc_mode_type mode_q;
  logic [2:0] prescale_q;
  logic [1:0] cpu_div_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_valid_q <= 1'b0;
      mode_q <= clock_ctrl_pkg::internal_osc_mode;
      prescale_q <= 3'h0;
      cpu_div_q <= 2'h0;
    end else if (!cfg_valid_q) begin
      cfg_valid_q <= 1'b1;
      mode_q <= clock_ctrl_pkg::osc_mode_type'(osc_mode_cfg);
      prescale_q <= pll_prescale_cfg;
      cpu_div_q <= cpu_clock_divider_select;
    end
  end

  logic mode_ext;
  logic mode_hs;
  logic mode_int_pll;
  logic mode_pll_capable;

  assign mode_ext = (mode_q == clock_ctrl_pkg::external_clock_mode) ||
                    (mode_q == clock_ctrl_pkg::external_clock_pll_mode);
  assign mode_hs = (mode_q == clock_ctrl_pkg::high_speed_crystal_mode) ||
                   (mode_q == clock_ctrl_pkg::high_speed_crystal_pll_mode);
  assign mode_int_pll = (mode_q == clock_ctrl_pkg::internal_osc_pll_mode) ||
                        (mode_q == clock_ctrl_pkg::internal_osc_pll_clkout_mode);
  assign mode_pll_capable = mode_int_pll || (mode_q == clock_ctrl_pkg::high_speed_crystal_pll_mode) ||
                            (mode_q == clock_ctrl_pkg::external_clock_pll_mode);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] tuning_q;
  logic [3:0] control_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tuning_q <= clock_ctrl_pkg::TUNING_RESET;
    end else if (reg_wr && reg_addr == clock_ctrl_pkg::ADDR_TUNING) begin
      tuning_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      control_q <= clock_ctrl_pkg::CONTROL_RESET;
    end else if (reg_wr && reg_addr == clock_ctrl_pkg::ADDR_CONTROL) begin
      control_q <= reg_wdata[3:0];
    end
  end

  logic low_src_fast;
  logic pll_enable_bit;
  logic signed [5:0] trim_target;
  logic use_internal;
  logic [2:0] freq_sel;

  assign low_src_fast = tuning_q[clock_ctrl_pkg::TUNE_SRC_BIT];
  assign pll_enable_bit = tuning_q[clock_ctrl_pkg::TUNE_PLL_BIT];
  assign trim_target = signed'(tuning_q[clock_ctrl_pkg::TRIM_W-1:0]);
  assign use_internal = control_q[clock_ctrl_pkg::CTRL_USE_INT_BIT];
  assign freq_sel = control_q[clock_ctrl_pkg::FREQ_SEL_W-1:0];

  // ----------------------------------------
  // Tick dividers
  // ----------------------------------------
  tick_div_if dv [clock_ctrl_pkg::DIV_COUNT] ();

  genvar gi;
  generate
    for (gi = 0; gi < clock_ctrl_pkg::DIV_COUNT; gi++) begin : g_div
      tick_divider u_div (
        .clk(clk),
        .rst_n(rst_n),
        .dv(dv[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Start-up and PLL lock
  // ----------------------------------------
  logic osc_ready_q;
  logic [15:0] start_cnt_q;
  logic pll_run_q;
  logic pll_locked_q;
  logic [15:0] lock_cnt_q;
  logic pll_run_d;

  // Crystal waits for start-up; external clock is ready at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_ready_q <= 1'b0;
      start_cnt_q <= 16'h0000;
    end else if (!cfg_valid_q || sleep_req) begin
      osc_ready_q <= 1'b0;
      start_cnt_q <= 16'h0000;
    end else if (!mode_hs) begin
      osc_ready_q <= 1'b1;
    end else if (!osc_ready_q && oscillator_input_pin) begin
      if (start_cnt_q == 16'(START_TICKS - 1)) begin
        osc_ready_q <= 1'b1;
      end
      start_cnt_q <= start_cnt_q + 16'h0001;
    end
  end

  // Selecting the postscaled internal clock also stops the PLL
  assign pll_run_d = cfg_valid_q && mode_pll_capable && pll_enable_bit && !use_internal && !sleep_req;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_run_q <= 1'b0;
    end else begin
      pll_run_q <= pll_run_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_locked_q <= 1'b0;
      lock_cnt_q <= 16'h0000;
    end else if (!pll_run_q || !pll_run_d) begin
      pll_locked_q <= 1'b0;
      lock_cnt_q <= 16'h0000;
    end else if (!pll_locked_q && dv[clock_ctrl_pkg::DV_PRESCALE].tick_out) begin
      if (lock_cnt_q == 16'(PLL_LOCK_TICKS - 1)) begin
        pll_locked_q <= 1'b1;
      end
      lock_cnt_q <= lock_cnt_q + 16'h0001;
    end
  end

  // ----------------------------------------
  // Clock paths
  // ----------------------------------------
  logic pll_src_tick;
  logic low_tick;
  logic int_tick;
  logic primary_tick;
  logic cpu_src_tick;
  logic clkout_src_tick;

  // Internal modes feed the 8 MHz fast oscillator to the PLL
  assign pll_src_tick = mode_int_pll ? fast_osc_tick : oscillator_input_pin;

  assign dv[clock_ctrl_pkg::DV_PRESCALE].clear = !pll_run_q;
  assign dv[clock_ctrl_pkg::DV_PRESCALE].tick_in = pll_src_tick;
  assign dv[clock_ctrl_pkg::DV_PRESCALE].divisor = clock_ctrl_pkg::prescale_div(prescale_q);

  // 96 MHz halved to the 48 MHz node
  assign dv[clock_ctrl_pkg::DV_PLL_HALF].clear = !pll_locked_q;
  assign dv[clock_ctrl_pkg::DV_PLL_HALF].tick_in = pll_vco_tick;
  assign dv[clock_ctrl_pkg::DV_PLL_HALF].divisor = clock_ctrl_pkg::DIV_PLL_HALF;

  // Postscaler: 4 MHz down to 125 kHz for selects 6..1
  assign dv[clock_ctrl_pkg::DV_POSTSCALE].clear = !cfg_valid_q;
  assign dv[clock_ctrl_pkg::DV_POSTSCALE].tick_in = fast_osc_tick;
  assign dv[clock_ctrl_pkg::DV_POSTSCALE].divisor = clock_ctrl_pkg::DIV_ONE << (3'h7 - freq_sel);

  assign dv[clock_ctrl_pkg::DV_LOW_FREQ].clear = !cfg_valid_q;
  assign dv[clock_ctrl_pkg::DV_LOW_FREQ].tick_in = fast_osc_tick;
  assign dv[clock_ctrl_pkg::DV_LOW_FREQ].divisor = clock_ctrl_pkg::DIV_LOW_FREQ;

  assign low_tick = low_src_fast ? dv[clock_ctrl_pkg::DV_LOW_FREQ].tick_out : slow_rc_tick;

  always_comb begin
    if (freq_sel == clock_ctrl_pkg::FREQ_SEL_FAST) begin
      int_tick = fast_osc_tick;
    end else if (freq_sel == clock_ctrl_pkg::FREQ_SEL_LOW) begin
      int_tick = low_tick;
    end else begin
      int_tick = dv[clock_ctrl_pkg::DV_POSTSCALE].tick_out;
    end
  end

  always_comb begin
    if (use_internal) begin
      primary_tick = int_tick;
    end else if (mode_ext || mode_hs) begin
      primary_tick = oscillator_input_pin;
    end else if (mode_int_pll) begin
      primary_tick = fast_osc_tick;
    end else begin
      primary_tick = int_tick;
    end
  end

  // Bypass clock until lock, then the PLL path
  assign cpu_src_tick = pll_locked_q ? dv[clock_ctrl_pkg::DV_PLL_HALF].tick_out : primary_tick;

  assign dv[clock_ctrl_pkg::DV_CPU].clear = !osc_ready_q;
  assign dv[clock_ctrl_pkg::DV_CPU].tick_in = cpu_src_tick;
  assign dv[clock_ctrl_pkg::DV_CPU].divisor = clock_ctrl_pkg::cpu_div(cpu_div_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_tick <= 1'b0;
    end else begin
      core_tick <= dv[clock_ctrl_pkg::DV_CPU].tick_out;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_ref_tick <= 1'b0;
      pll_power_en <= 1'b0;
    end else begin
      pll_ref_tick <= dv[clock_ctrl_pkg::DV_PRESCALE].tick_out;
      pll_power_en <= pll_run_d;
    end
  end

  // ----------------------------------------
  // Clock output pin
  // ----------------------------------------
  assign clkout_src_tick = pll_locked_q ? pll_vco_tick : oscillator_input_pin;

  assign dv[clock_ctrl_pkg::DV_CLKOUT].clear = !mode_ext;
  assign dv[clock_ctrl_pkg::DV_CLKOUT].tick_in = clkout_src_tick;
  assign dv[clock_ctrl_pkg::DV_CLKOUT].divisor = clock_ctrl_pkg::DIV_CLKOUT_HALF;

  // Toggle every second edge gives a quarter-rate square wave
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oscillator_output_pin_o <= 1'b0;
      oscillator_output_pin_oe <= 1'b0;
    end else begin
      oscillator_output_pin_oe <= mode_ext && cfg_valid_q && !sleep_req;
      if (!mode_ext) begin
        oscillator_output_pin_o <= 1'b0;
      end else if (dv[clock_ctrl_pkg::DV_CLKOUT].tick_out) begin
        oscillator_output_pin_o <= !oscillator_output_pin_o;
      end
    end
  end

  // ----------------------------------------
  // Slow RC enable and fast trim
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_rc_run <= 1'b0;
    end else begin
      slow_rc_run <= (primary_tick_is_rc() ) || powerup_timer_en || failsafe_monitor_en ||
                     watchdog_en || two_speed_start_en;
    end
  end

  function automatic logic primary_tick_is_rc();
    return (use_internal || !(mode_ext || mode_hs || mode_int_pll)) &&
           (freq_sel == clock_ctrl_pkg::FREQ_SEL_LOW) && !low_src_fast;
  endfunction

  // One linear step per fast oscillator tick toward the written value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_osc_trim <= 6'sh00;
    end else if (fast_osc_tick && fast_osc_trim != trim_target) begin
      if (fast_osc_trim < trim_target) begin
        fast_osc_trim <= fast_osc_trim + 6'sh01;
      end else begin
        fast_osc_trim <= fast_osc_trim - 6'sh01;
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [7:0] status;

  always_comb begin
    status = 8'h00;
    status[clock_ctrl_pkg::STAT_LOCK_BIT] = pll_locked_q;
    status[clock_ctrl_pkg::STAT_PLL_RUN_BIT] = pll_run_q;
    status[clock_ctrl_pkg::STAT_READY_BIT] = osc_ready_q;
    status[clock_ctrl_pkg::STAT_SLOW_RC_BIT] = slow_rc_run;
    status[clock_ctrl_pkg::STAT_MODE_LSB +: 3] = mode_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        clock_ctrl_pkg::ADDR_TUNING: reg_rdata <= tuning_q;
        clock_ctrl_pkg::ADDR_CONTROL: reg_rdata <= {4'h0, control_q};
        clock_ctrl_pkg::ADDR_STATUS: reg_rdata <= status;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule // osc_clock_ctrl

// File: core/tick_div_if.sv
// Carrier between the clock controller and its tick dividers
`timescale 1ns/1ps
interface tick_div_if;
  logic clear;
  logic tick_in;
  logic [8:0] divisor;
  logic tick_out;
  modport owner (output clear, output tick_in, output divisor, input tick_out);
  modport divider (input clear, input tick_in, input divisor, output tick_out);
endinterface

// File: core/tick_divider.sv
// Divides a stream of one-cycle tick pulses by a programmable count
`timescale 1ns/1ps
module tick_divider (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Divider carrier
  tick_div_if.divider dv
);

  logic [8:0] count_q;
  logic [8:0] count_next;
  logic last;

  assign count_next = count_q + 9'h001;
  // Divisor zero behaves as one
  assign last = (count_next >= dv.divisor);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 9'h000;
    end else if (dv.clear) begin
      count_q <= 9'h000;
    end else if (dv.tick_in) begin
      count_q <= last ? 9'h000 : count_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dv.tick_out <= 1'b0;
    end else begin
      dv.tick_out <= dv.tick_in && last && !dv.clear;
    end
  end

endmodule // tick_divider

// File: test/osc_clock_ctrl_asserts.sv
// Concurrent checks on the clock control block ports
`timescale 1ns/1ps
module osc_clock_ctrl_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Straps and ticks
  input wire logic [2:0] osc_mode_cfg,
  input wire logic [1:0] cpu_clock_divider_select,
  input wire logic oscillator_input_pin,
  input wire logic fast_osc_tick,
  // Feature enables
  input wire logic powerup_timer_en,
  input wire logic failsafe_monitor_en,
  input wire logic watchdog_en,
  input wire logic two_speed_start_en,
  input wire logic sleep_req,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Clock outputs
  input wire logic core_tick,
  input wire logic pll_ref_tick,
  input wire logic pll_power_en,
  input wire logic slow_rc_run,
  input wire logic signed [5:0] fast_osc_trim,
  input wire logic oscillator_output_pin_o,
  input wire logic oscillator_output_pin_oe
);
  // ----
  // Register shadows
  // ----
  logic [7:0] tune_q;
  logic use_int_q;
  logic pll_bit;
  logic pll_mode;
  logic feat_on;
  assign pll_bit = tune_q[6];
  assign pll_mode = osc_mode_cfg inside {3'h2, 3'h3, 3'h5, 3'h7};
  assign feat_on = powerup_timer_en || failsafe_monitor_en || watchdog_en || two_speed_start_en;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tune_q <= 8'h00;
    end else if (reg_wr && reg_addr == 4'h0) begin
      tune_q <= reg_wdata;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      use_int_q <= 1'b0;
    end else if (reg_wr && reg_addr == 4'h1) begin
      use_int_q <= reg_wdata[3];
    end
  end
  // ----
  // Properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_PLL_NONPLL_OFF: assert property (!pll_mode |-> !pll_power_en)
    else $error("pll powered in a non-pll mode");
  AST_PLL_NEEDS_BIT: assert property (pll_power_en |-> pll_bit || $past(pll_bit))
    else $error("pll powered with enable bit clear");
  AST_PLL_RUNS: assert property ((pll_mode && pll_bit && !use_int_q && !sleep_req) [*3] |-> pll_power_en)
    else $error("pll not powered though enabled");
  AST_SLOW_RC_FEATURE: assert property (feat_on [*2] |-> slow_rc_run)
    else $error("slow rc stopped while a feature needs it");
  AST_CLKOUT_EXT_ONLY: assert property (osc_mode_cfg[2:1] != 2'h3 |-> !oscillator_output_pin_oe && !oscillator_output_pin_o)
    else $error("clock out active outside external modes");
  AST_TRIM_ON_TICK: assert property ($changed(fast_osc_trim) |-> $past(fast_osc_tick) || $past(fast_osc_tick, 2))
    else $error("trim moved without a fast tick");
  AST_TRIM_ONE_LSB: assert property ($changed(fast_osc_trim) |-> 6'(fast_osc_trim - $past(fast_osc_trim)) inside {6'h01, 6'h3f})
    else $error("trim step larger than one lsb");
  AST_TUNING_READ: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata == tune_q)
    else $error("tuning readback differs from written value");
  AST_CPU_SIXTH: assert property (cpu_clock_divider_select == 2'h0 && core_tick |=> !core_tick [*5])
    else $error("core tick too soon for divide by six");
  AST_REF_FROM_INPUT: assert property (pll_ref_tick |-> $past(oscillator_input_pin) || $past(oscillator_input_pin, 2)
    || $past(oscillator_input_pin, 3) || $past(fast_osc_tick) || $past(fast_osc_tick, 2) || $past(fast_osc_tick, 3))
    else $error("reference tick without source tick");
  COV_PLL_ON: cover property ($rose(pll_power_en));
  COV_CLKOUT: cover property ($rose(oscillator_output_pin_o));
  COV_TRIM: cover property ($changed(fast_osc_trim));
endmodule // osc_clock_ctrl_asserts

// File: test/osc_clock_ctrl_tb.sv
// Self-checking testbench for the clock control block
`timescale 1ns/1ps
module osc_clock_ctrl_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] mode = 3'h6;
  logic [2:0] pre = 3'h7;
  logic [1:0] cdiv = 2'h3;
  logic [3:0] tk = 4'h0;
  logic [3:0] feat = 4'h0;
  logic sleep = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic core, ref_t, pwr, rc_run, pin_o, pin_oe, pin_prev;
  logic signed [5:0] trim;
  int n_fail = 0;
  int check_count = 0;
  int seed = 32'h025a;
  int n_core = 0;
  int n_ref = 0;
  int n_tog = 0;
  osc_clock_ctrl #(.PLL_LOCK_TICKS(4), .START_TICKS(8)) i_dut (.clk(clk), .rst_n(rst_n),
    .osc_mode_cfg(mode), .pll_prescale_cfg(pre), .cpu_clock_divider_select(cdiv),
    .oscillator_input_pin(tk[0]), .fast_osc_tick(tk[1]), .slow_rc_tick(tk[2]), .pll_vco_tick(tk[3]),
    .powerup_timer_en(feat[0]), .failsafe_monitor_en(feat[1]), .watchdog_en(feat[2]),
    .two_speed_start_en(feat[3]), .sleep_req(sleep), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .core_tick(core), .pll_ref_tick(ref_t),
    .pll_power_en(pwr), .slow_rc_run(rc_run), .fast_osc_trim(trim),
    .oscillator_output_pin_o(pin_o), .oscillator_output_pin_oe(pin_oe));
  // ----
  // Clock, counters and tasks
  // ----
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    n_core <= n_core + int'(core === 1'b1);
    n_ref <= n_ref + int'(ref_t === 1'b1);
    n_tog <= n_tog + int'(pin_o !== pin_prev);
    pin_prev <= pin_o;
  end
  task automatic complete_run;
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset(input logic [2:0] m, input logic [2:0] p, input logic [1:0] c);
    @(posedge clk);
    rst_n <= 1'b0;
    mode <= m;
    pre <= p;
    cdiv <= c;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    settle(1);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge clk);
      tk[k] <= 1'b1;
      @(posedge clk);
      tk[k] <= 1'b0;
      @(posedge clk);
    end
    settle(6);
  endtask
  function automatic int cpu_ratio(input logic [1:0] s);
    return (s == 2'h3) ? 1 : (s == 2'h2) ? 2 : (s == 2'h1) ? 3 : 6;
  endfunction
  function automatic int pre_ratio(input logic [2:0] s);
    int t[8] = '{12, 10, 6, 5, 4, 3, 2, 1};
    return t[s];
  endfunction
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    complete_run;
  end
  // ----
  // Scenarios
  // ----
  initial begin
    logic [7:0] r;
    int c0, t0, e, v, p;
    do_reset(3'h6, 3'h7, 2'h3);
    rd_reg(4'h0, r);
    check(r, 8'h00);
    wr_reg(4'h2, 8'hff);
    rd_reg(4'h2, r);
    check(r, 8'h64);
    rd_reg(4'h5, r);
    check(r, 8'h00);
    for (int s = 0; s < 4; s++) begin
      do_reset(3'h6, 3'h7, s[1:0]);
      c0 = n_core;
      t0 = n_tog;
      pulse(0, 48);
      check(16'(n_core - c0), 16'(48 / cpu_ratio(s[1:0])));
      check(16'(n_tog - t0), 16'h0018);
      check(pin_oe, 1'b1);
    end
    @(posedge clk);
    sleep <= 1'b1;
    settle(2);
    check(pin_oe, 1'b0);
    @(posedge clk);
    sleep <= 1'b0;
    settle(2);
    rd_reg(4'h2, r);
    check(r[2], 1'b1);
    check(pin_oe, 1'b1);
    for (int m = 0; m < 8; m++) begin
      do_reset(m[2:0], 3'h6, 2'h3);
      rd_reg(4'h2, r);
      if (m >= 6) check(r[2], 1'b1);
      wr_reg(4'h0, 8'h40);
      settle(3);
      check(pwr, m inside {2, 3, 5, 7});
      wr_reg(4'h0, 8'h00);
      settle(3);
      check(pwr, 1'b0);
    end
    for (int q = 0; q < 8; q++) begin
      do_reset(3'h7, q[2:0], 2'h3);
      wr_reg(4'h0, 8'h40);
      c0 = n_ref;
      pulse(0, 120);
      check(16'(n_ref - c0), 16'(120 / pre_ratio(q[2:0])));
    end
    do_reset(3'h7, 3'h7, 2'h3);
    wr_reg(4'h0, 8'h40);
    c0 = n_core;
    pulse(0, 2);
    check(16'(n_core - c0), 16'h0002);
    rd_reg(4'h2, r);
    check(r[0], 1'b0);
    pulse(0, 4);
    for (int i = 0; i < 20 && r[0] !== 1'b1; i++) rd_reg(4'h2, r);
    check(r[0], 1'b1);
    if (r[0] !== 1'b1) complete_run;
    c0 = n_core;
    t0 = n_tog;
    pulse(3, 20);
    check(16'(n_core - c0), 16'h000a);
    check(16'(n_tog - t0), 16'h000a);
    do_reset(3'h6, 3'h7, 2'h3);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      feat <= 4'($random(seed));
      settle(3);
      check(rc_run, |feat);
    end
    feat <= 4'h0;
    do_reset(3'h0, 3'h6, 2'h3);
    p = 0;
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 31 : (i == 1) ? -32 : (i == 2) ? 0 : $signed(6'($random(seed)));
      wr_reg(4'h0, {2'h0, 6'(v)});
      pulse(1, 1);
      e = (v > p) ? p + 1 : (v < p) ? p - 1 : p;
      check(16'(trim), 16'(e));
      pulse(1, 63);
      check(16'(trim), 16'(v));
      rd_reg(4'h0, r);
      check(r, {2'h0, 6'(v)});
      p = v;
    end
    for (int s = 0; s < 8; s++) begin
      do_reset(3'h0, 3'h6, 2'h3);
      wr_reg(4'h0, 8'h80);
      wr_reg(4'h1, {5'h01, s[2:0]});
      c0 = n_core;
      pulse(1, 256);
      check(16'(n_core - c0), 16'(s == 7 ? 256 : s == 0 ? 1 : 256 >> (7 - s)));
    end
    wr_reg(4'h0, 8'h00);
    wr_reg(4'h1, 8'h08);
    c0 = n_core;
    pulse(2, 8);
    check(16'(n_core - c0), 16'h0008);
    check(rc_run, 1'b1);
    complete_run;
  end
endmodule // osc_clock_ctrl_tb
bind osc_clock_ctrl osc_clock_ctrl_asserts i_chk (.clk(clk), .rst_n(rst_n), .osc_mode_cfg(osc_mode_cfg),
  .cpu_clock_divider_select(cpu_clock_divider_select), .oscillator_input_pin(oscillator_input_pin),
  .fast_osc_tick(fast_osc_tick), .powerup_timer_en(powerup_timer_en), .failsafe_monitor_en(failsafe_monitor_en),
  .watchdog_en(watchdog_en), .two_speed_start_en(two_speed_start_en), .sleep_req(sleep_req),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .core_tick(core_tick), .pll_ref_tick(pll_ref_tick), .pll_power_en(pll_power_en), .slow_rc_run(slow_rc_run),
  .fast_osc_trim(fast_osc_trim), .oscillator_output_pin_o(oscillator_output_pin_o),
  .oscillator_output_pin_oe(oscillator_output_pin_oe));
